// File: pkg/wwdt_pkg.sv
// shared constants and types for the windowed watchdog timer
package wwdt_pkg;

  // ==================================================================
  // reset control register layout (bit positions)
  localparam int unsigned RCTL_IDLE_BIT  = 2;
  localparam int unsigned RCTL_SLEEP_BIT = 3;
  localparam int unsigned RCTL_WATCHDOG_TIMEOUT_FLAG_BIT  = 4;
  localparam int unsigned RCTL_SWEN_BIT  = 5;
  localparam logic [7:0]  RCTL_RESET     = 8'h00;

  // ==================================================================
  // register port map (byte offsets)
  localparam logic [3:0] ADDR_RCTL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hc;
  localparam logic [3:0] IRQ_RESET = 4'h0;

  // interrupt status bits
  localparam int unsigned IRQ_TIMEOUT_BIT = 0;
  localparam int unsigned IRQ_WAKE_BIT    = 1;
  localparam int unsigned IRQ_EARLY_BIT   = 2;

  // ==================================================================
  // configuration word one bit positions
  localparam int unsigned CW1_PS_LSB    = 0;
  localparam int unsigned CW1_PRE_BIT   = 4;
  localparam int unsigned CW1_WINDOW_DISABLE_CFG_BIT = 6;
  localparam int unsigned CW1_HWEN_BIT  = 7;

  // ==================================================================
  // timing
  localparam int unsigned LOW_POWER_RC_OSC_FREQ_HZ     = 31000;
  localparam int unsigned CORE_FREQ_HZ     = 100000000;
  localparam int unsigned PRESCALE_SHORT   = 32;
  localparam int unsigned PRESCALE_LONG    = 128;
  localparam int unsigned POSTSCALE_STEPS  = 16;
  localparam int unsigned BASE_TMO_SHORT_MS = 1;
  localparam int unsigned BASE_TMO_LONG_MS  = 4;

  typedef struct packed {
    logic       hw_watchdog_enable_cfg;
    logic       window_disable_cfg;
    logic       prescale_select_cfg;
    logic [3:0] postscale_select_cfg;
  } wwdt_cfg_t;

  typedef struct packed {
    logic power_save_enter;
    logic power_save_exit;
    logic clock_switch_done;
    logic watchdog_clear_instr;
    logic to_sleep;
  } wwdt_core_ev_t;

endpackage : wwdt_pkg

// File: core/wwdt_sync.sv
// three-stage synchroniser with agreement filter for one level
`timescale 1ns/1ps
`default_nettype none
module wwdt_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // level
  input  wire logic async_in,
  output logic      sync_out
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       out_q;
  logic       out_d;

  always_comb
  begin
    stage_d = {stage_q[1:0], async_in};
    out_d   = out_q;
    // stage 0 only feeds stage 1; stages 1 and 2 must agree
    if (stage_q[1] == stage_q[2])
    begin
      out_d = stage_q[2];
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stage_q <= 3'h0;
      out_q   <= 1'b0;
    end
    else
    begin
      stage_q <= stage_d;
      out_q   <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule : wwdt_sync
`default_nettype wire

// File: core/wwdt_top.sv
// windowed watchdog timer counting on the low-power rc oscillator
`timescale 1ns/1ps
`default_nettype none
module wwdt_top #(
  parameter int unsigned POST_W = 15
) (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   nrst,
  // low-power rc oscillator
  input  wire logic                   low_power_rc_osc,
  output logic                        low_power_rc_osc_enable,
  // configuration word one
  input  wire wwdt_pkg::wwdt_cfg_t    cfg,
  // core events, one-cycle pulses
  input  wire wwdt_pkg::wwdt_core_ev_t core_ev,
  // register port
  input  wire logic [3:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [7:0]                  reg_rdata,
  // results
  output logic                        device_reset_req,
  output logic                        core_wake,
  output logic                        irq
);
  // ==================================================================
  // oscillator edge detection
  logic osc_s;
  logic osc_prev_q;
  logic osc_prev_d;
  logic osc_tick;

  wwdt_sync u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in (low_power_rc_osc),
    .sync_out (osc_s)
  );

  // ==================================================================
  // state
  typedef enum logic [1:0] {WWDT_RUN, WWDT_SLEEP, WWDT_IDLE} wwdt_mode_t;

  wwdt_mode_t        mode_q;
  wwdt_mode_t        mode_d;
  logic [6:0]        pre_q;
  logic [6:0]        pre_d;
  logic [POST_W-1:0] post_q;
  logic [POST_W-1:0] post_d;
  logic [7:0]        rctl_q;
  logic [7:0]        rctl_d;
  logic [3:0]        ist_q;
  logic [3:0]        ist_d;
  logic [3:0]        imask_q;
  logic [3:0]        imask_d;
  logic [7:0]        rdata_q;
  logic [7:0]        rdata_d;
  logic              rst_req_q;
  logic              rst_req_d;
  logic              wake_q;
  logic              wake_d;

  logic              wdt_on;
  logic              window_on;
  logic              pre_wrap;
  logic              timeout;
  logic              in_window;
  logic              early_clear;
  logic              clr_counters;
  logic [POST_W-1:0] post_last;
  logic [POST_W+9:0] elapsed;
  logic [POST_W+9:0] period;

  // postscale terminal count: ratio 2^sel, capped at the counter width
  function automatic logic [POST_W-1:0] post_terminal(input logic [3:0] sel);
    logic [POST_W:0] one_hot;
    one_hot = '0;
    one_hot[(sel > 4'(POST_W)) ? POST_W : sel] = 1'b1;
    post_terminal = POST_W'(one_hot - (POST_W+1)'(1));
  endfunction : post_terminal

  // last prescale count for the selected stage
  function automatic logic [7:0] pre_top(input logic long_sel);
    pre_top = long_sel ? 8'(wwdt_pkg::PRESCALE_LONG - 1) : 8'(wwdt_pkg::PRESCALE_SHORT - 1);
  endfunction : pre_top

  // true when a byte-wide write targets the given offset
  function automatic logic wr_hit(input logic [3:0] a);
    wr_hit = reg_wr && (reg_addr == a);
  endfunction : wr_hit

  // ==================================================================
  // enables and counting
  always_comb
  begin
    wdt_on      = cfg.hw_watchdog_enable_cfg || rctl_q[wwdt_pkg::RCTL_SWEN_BIT];
    window_on   = !cfg.window_disable_cfg;
    osc_prev_d  = osc_s;
    osc_tick    = wdt_on && osc_s && !osc_prev_q;
    // prescale of 32 or 128 gives 1 ms or 4 ms at 31 kHz
    pre_wrap    = cfg.prescale_select_cfg ? (pre_q == 7'(wwdt_pkg::PRESCALE_LONG - 1))
                                          : (pre_q[4:0] == 5'(wwdt_pkg::PRESCALE_SHORT - 1));
    post_last   = post_terminal(cfg.postscale_select_cfg);
    timeout     = osc_tick && pre_wrap && (post_q == post_last);
    // last quarter: ticks so far at or beyond three quarters of the whole period
    period      = ((POST_W+10)'(post_last) + (POST_W+10)'(1))
                  * ((POST_W+10)'(pre_top(cfg.prescale_select_cfg)) + (POST_W+10)'(1));
    elapsed     = (POST_W+10)'(post_q) * ((POST_W+10)'(pre_top(cfg.prescale_select_cfg)) + (POST_W+10)'(1))
                  + (POST_W+10)'(pre_q);
    in_window   = (elapsed << 2) >= ((period << 1) + period);
    early_clear = core_ev.watchdog_clear_instr && wdt_on && window_on
                  && (mode_q == WWDT_RUN) && !in_window;
    clr_counters = core_ev.watchdog_clear_instr || core_ev.clock_switch_done
                   || core_ev.power_save_enter || core_ev.power_save_exit || !wdt_on;
  end

  always_comb
  begin
    pre_d  = pre_q;
    post_d = post_q;
    if (clr_counters || timeout)
    begin
      pre_d  = 7'h00;
      post_d = '0;
    end
    else if (osc_tick)
    begin
      if (pre_wrap)
      begin
        pre_d  = 7'h00;
        post_d = post_q + POST_W'(1);
      end
      else
      begin
        pre_d = pre_q + 7'h01;
      end
    end
  end

  // ==================================================================
  // mode, reset control, interrupts and register port
  always_comb
  begin
    mode_d    = mode_q;
    rctl_d    = rctl_q;
    ist_d     = ist_q;
    imask_d   = imask_q;
    rst_req_d = 1'b0;
    wake_d    = 1'b0;
    rdata_d   = 8'h00;

    if (core_ev.power_save_enter)
    begin
      mode_d = core_ev.to_sleep ? WWDT_SLEEP : WWDT_IDLE;
    end
    else if (core_ev.power_save_exit)
    begin
      mode_d = WWDT_RUN;
    end

    // software writes first so that hardware sets win in the same cycle
    if (wr_hit(wwdt_pkg::ADDR_RCTL))
    begin
      rctl_d = reg_wdata & 8'h3c;
    end
    if (wr_hit(wwdt_pkg::ADDR_IRQ_STATUS))
    begin
      ist_d = ist_q & ~reg_wdata[3:0];
    end
    if (wr_hit(wwdt_pkg::ADDR_IRQ_MASK))
    begin
      imask_d = reg_wdata[3:0];
    end

    if (core_ev.power_save_enter)
    begin
      if (core_ev.to_sleep)
      begin
        rctl_d[wwdt_pkg::RCTL_SLEEP_BIT] = 1'b1;
      end
      else
      begin
        rctl_d[wwdt_pkg::RCTL_IDLE_BIT] = 1'b1;
      end
    end

    if (timeout || early_clear)
    begin
      rctl_d[wwdt_pkg::RCTL_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b1;
      ist_d[wwdt_pkg::IRQ_TIMEOUT_BIT] = 1'b1;
      if (early_clear)
      begin
        ist_d[wwdt_pkg::IRQ_EARLY_BIT] = 1'b1;
      end
      if (timeout && (mode_q != WWDT_RUN))
      begin
        wake_d = 1'b1;
        mode_d = WWDT_RUN;
        ist_d[wwdt_pkg::IRQ_WAKE_BIT] = 1'b1;
      end
      else
      begin
        rst_req_d = 1'b1;
        rctl_d[wwdt_pkg::RCTL_SWEN_BIT] = 1'b0;
        mode_d = WWDT_RUN;
      end
    end

    if (reg_rd)
    begin
      unique case (reg_addr)
        wwdt_pkg::ADDR_RCTL:       rdata_d = rctl_q;
        wwdt_pkg::ADDR_IRQ_STATUS: rdata_d = {4'h0, ist_q};
        wwdt_pkg::ADDR_IRQ_MASK:   rdata_d = {4'h0, imask_q};
        wwdt_pkg::ADDR_COUNT:      rdata_d = post_q[7:0];
        default:                   rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_prev_q <= 1'b0;
      pre_q      <= 7'h00;
      post_q     <= '0;
      mode_q     <= WWDT_RUN;
      rctl_q     <= wwdt_pkg::RCTL_RESET;
      ist_q      <= wwdt_pkg::IRQ_RESET;
      imask_q    <= wwdt_pkg::IRQ_RESET;
      rdata_q    <= 8'h00;
      rst_req_q  <= 1'b0;
      wake_q     <= 1'b0;
    end
    else
    begin
      osc_prev_q <= osc_prev_d;
      pre_q      <= pre_d;
      post_q     <= post_d;
      mode_q     <= mode_d;
      rctl_q     <= rctl_d;
      ist_q      <= ist_d;
      imask_q    <= imask_d;
      rdata_q    <= rdata_d;
      rst_req_q  <= rst_req_d;
      wake_q     <= wake_d;
    end
  end

  // ==================================================================
  // outputs
  assign low_power_rc_osc_enable      = wdt_on;
  assign reg_rdata        = rdata_q;
  assign device_reset_req = rst_req_q;
  assign core_wake        = wake_q;
  assign irq              = |(ist_q & imask_q);
endmodule : wwdt_top
`default_nettype wire

// File: tb/wwdt_properties.sv
// port assertions for the windowed watchdog timer
`timescale 1ns/1ps
`default_nettype none
module wwdt_properties (
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    nrst,
  // block inputs
  input wire wwdt_pkg::wwdt_cfg_t     cfg,
  input wire wwdt_pkg::wwdt_core_ev_t core_ev,
  input wire logic [3:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  // block outputs
  input wire logic [7:0]              reg_rdata,
  input wire logic                    low_power_rc_osc_enable,
  input wire logic                    device_reset_req,
  input wire logic                    core_wake
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // ==================================================================
  // power-save tracking
  logic asleep_q;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      asleep_q <= 1'b0;
    else if (core_ev.power_save_enter)
      asleep_q <= 1'b1;
    else if (core_ev.power_save_exit || core_wake)
      asleep_q <= 1'b0;
  end
  // ==================================================================
  // properties
  sequence s_restart;
    core_ev.clock_switch_done && low_power_rc_osc_enable;
  endsequence
  sequence s_clear;
    core_ev.watchdog_clear_instr;
  endsequence
  property p_early;
    s_restart ##2 s_clear ##0 !cfg.window_disable_cfg |-> ##[1:3] device_reset_req;
  endproperty
  a_early: assert property (p_early) else $error("early clear gave no reset");
  property p_open;
    s_restart ##2 s_clear ##0 cfg.window_disable_cfg |=> !device_reset_req [*3];
  endproperty
  a_open: assert property (p_open) else $error("clear reset without window");
  property p_hw_on;
    cfg.hw_watchdog_enable_cfg |-> low_power_rc_osc_enable;
  endproperty
  a_hw_on: assert property (p_hw_on) else $error("forced enable lost");
  property p_sw_off;
    reg_wr && reg_addr == wwdt_pkg::ADDR_RCTL && !reg_wdata[wwdt_pkg::RCTL_SWEN_BIT]
      && !cfg.hw_watchdog_enable_cfg |=> !low_power_rc_osc_enable;
  endproperty
  a_sw_off: assert property (p_sw_off) else $error("software stop ignored");
  property p_sw_on;
    reg_wr && reg_addr == wwdt_pkg::ADDR_RCTL && reg_wdata[wwdt_pkg::RCTL_SWEN_BIT] |=> low_power_rc_osc_enable;
  endproperty
  a_sw_on: assert property (p_sw_on) else $error("oscillator not enabled");
  property p_idle;
    !low_power_rc_osc_enable && !$past(low_power_rc_osc_enable) |-> !device_reset_req && !core_wake;
  endproperty
  a_idle: assert property (p_idle) else $error("event while disabled");
  property p_rst_pulse;
    device_reset_req |=> !device_reset_req;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse too long");
  property p_wake_pulse;
    core_wake |=> !core_wake;
  endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake pulse too long");
  property p_sleep;
    asleep_q |-> !device_reset_req;
  endproperty
  a_sleep: assert property (p_sleep) else $error("reset while asleep");
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
endmodule : wwdt_properties

bind wwdt_top wwdt_properties i_props (.core_clk(core_clk), .nrst(nrst), .cfg(cfg), .core_ev(core_ev),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .low_power_rc_osc_enable(low_power_rc_osc_enable), .device_reset_req(device_reset_req), .core_wake(core_wake));
`default_nettype wire

// File: tb/wwdt_top_test.sv
// self-checking bench for the windowed watchdog timer
`timescale 1ns/1ps
`default_nettype none
module wwdt_top_test;
  logic                    core_clk, nrst, osc, wr, rd, low_power_rc_osc_en, rst_req, wake, irq;
  logic [3:0]              addr;
  logic [7:0]              wdata, rdata;
  wwdt_pkg::wwdt_cfg_t     cfg;
  wwdt_pkg::wwdt_core_ev_t ev;
  int                      fails, checks_done, cycles, n, i;

  wwdt_top #(.POST_W(15)) i_dut (.core_clk(core_clk), .nrst(nrst), .low_power_rc_osc(osc), .low_power_rc_osc_enable(low_power_rc_osc_en),
    .cfg(cfg), .core_ev(ev), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .device_reset_req(rst_req), .core_wake(wake), .irq(irq));

  // ==================================================================
  // clocks: oscillator period of 8 cycles keeps every time-out short
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    osc = 1'b0;
    forever #40 osc = ~osc;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      final_report();
    end
  end

  // ==================================================================
  // tasks
  task automatic final_report;
    if (fails == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 check(rdata & m, e);
  endtask : rd_reg
  task automatic fire(input logic [4:0] v);
    @(posedge core_clk);
    ev <= wwdt_pkg::wwdt_core_ev_t'(v);
    @(posedge core_clk);
    ev <= '0;
  endtask : fire
  task automatic measure(output int k);
    k = 0;
    #1;
    // look in the cycle right after the last event too: a result pulse stands only one cycle
    while (rst_req !== 1'b1 && wake !== 1'b1 && k < 3000)
    begin
      @(posedge core_clk);
      #1 k++;
    end
  endtask : measure
  // a counter restart 100 cycles into the period must push the time-out out by a full period
  task automatic run(input logic pre, input logic [3:0] sel, input logic [4:0] evv);
    int e;
    e = 8 * ((pre ? wwdt_pkg::PRESCALE_LONG : wwdt_pkg::PRESCALE_SHORT) << sel);
    @(posedge core_clk);
    cfg.prescale_select_cfg  <= pre;
    cfg.postscale_select_cfg <= sel;
    wr_reg(wwdt_pkg::ADDR_RCTL, 8'h20);
    repeat (100) @(posedge core_clk);
    fire(evv);
    measure(n);
    check({7'h00, n >= e - 12 && n <= e + 16}, 8'h01);
  endtask : run

  // ==================================================================
  // main sequence
  initial
  begin
    nrst = 1'b0;
    {wr, rd, addr, wdata} = '0;
    ev = '0;
    cfg = '0;
    cfg.window_disable_cfg = 1'b1;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd_reg(wwdt_pkg::ADDR_RCTL, 8'hff, 8'h00);
    check({7'h00, low_power_rc_osc_en}, 8'h00);
    wr_reg(4'h2, 8'hff);
    rd_reg(4'h2, 8'hff, 8'h00);
    run(1'b0, 4'h0, 5'h04);
    rd_reg(wwdt_pkg::ADDR_RCTL, 8'hff, 8'h10);
    check({7'h00, irq}, 8'h00);
    wr_reg(wwdt_pkg::ADDR_IRQ_MASK, 8'h01);
    check({7'h00, irq}, 8'h01);
    wr_reg(wwdt_pkg::ADDR_IRQ_STATUS, 8'h01);
    check({7'h00, irq}, 8'h00);
    rd_reg(wwdt_pkg::ADDR_RCTL, 8'hff, 8'h10);
    wr_reg(wwdt_pkg::ADDR_RCTL, 8'h00);
    rd_reg(wwdt_pkg::ADDR_RCTL, 8'hff, 8'h00);
    run(1'b0, 4'h1, 5'h08);
    run(1'b1, 4'h0, 5'h02);
    run(1'b0, 4'h2, 5'h04);
    for (i = 0; i < 2; i++)
    begin
      run(1'b0, 4'h0, i ? 5'h11 : 5'h10);
      check({7'h00, wake}, 8'h01);
      rd_reg(wwdt_pkg::ADDR_RCTL, 8'h2c, i ? 8'h28 : 8'h24);
      fire(5'h08);
      rd_reg(wwdt_pkg::ADDR_RCTL, 8'h2c, i ? 8'h28 : 8'h24);
      wr_reg(wwdt_pkg::ADDR_RCTL, 8'h00);
      rd_reg(wwdt_pkg::ADDR_RCTL, 8'h2c, 8'h00);
    end
    cfg.hw_watchdog_enable_cfg <= 1'b1;
    wr_reg(wwdt_pkg::ADDR_RCTL, 8'h00);
    check({7'h00, low_power_rc_osc_en}, 8'h01);
    fire(5'h04);
    fire(5'h02);
    measure(n);
    check({7'h00, rst_req}, 8'h01);
    check({7'h00, n > 230}, 8'h01);
    cfg.hw_watchdog_enable_cfg <= 1'b0;
    cfg.window_disable_cfg     <= 1'b0;
    wr_reg(wwdt_pkg::ADDR_RCTL, 8'h20);
    fire(5'h04);
    fire(5'h02);
    measure(n);
    check({7'h00, rst_req === 1'b1 && n < 5}, 8'h01);
    rd_reg(wwdt_pkg::ADDR_IRQ_STATUS, 8'h04, 8'h04);
    rd_reg(wwdt_pkg::ADDR_RCTL, 8'h30, 8'h10);
    wr_reg(wwdt_pkg::ADDR_RCTL, 8'h20);
    fire(5'h04);
    repeat (215) @(posedge core_clk);
    fire(5'h02);
    measure(n);
    check({7'h00, n > 244 && n < 272}, 8'h01);
    final_report();
  end
endmodule : wwdt_top_test
`default_nettype wire
